// ===== bench/host_model.sv
`timescale 1ns/1ns
// host side: register and select writes, driven just after an edge
module host_model (
  input  wire logic       i_clock,
  output logic            o_wr,
  output logic            o_sel_wr,
  output logic            o_sel_val,
  output logic [7:0]      o_addr,
  output logic [7:0]      o_data
);
  initial {o_wr, o_sel_wr, o_sel_val, o_addr, o_data} = '0;
  // one strobe for one sampled edge, then bus left showing junk
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clock) #1;
    {o_wr, o_addr, o_data} = {1'b1, a, d};
    @(posedge i_clock) #1;
    {o_wr, o_addr, o_data} = {1'b0, ~a, ~d};
  endtask
  // select write, then the host waits out the trim transfer
  task sel(input logic v);
    @(posedge i_clock) #1;
    {o_sel_wr, o_sel_val} = {1'b1, v};
    @(posedge i_clock) #1;
    {o_sel_wr, o_sel_val} = {1'b0, ~v};
    repeat (20) @(posedge i_clock);
  endtask
endmodule // host_model

// ===== bench/pwr_defaults_asserts.sv
`timescale 1ns/1ns
// watches power-up defaults and the trim register at the ports
module pwr_defaults_asserts #(
  parameter [7:0] FACTORY_TRIM = 8'h00
) (
  input wire logic       i_clock, i_srst, i_power_up, i_retained,
  input wire logic       i_reg_wr, i_otp_select_wr, i_otp_select_val,
  input wire logic [7:0] i_reg_addr, i_reg_wdata, o_analog_trim,
  input wire logic       o_trim_valid, o_oscillator_stop, o_output_level,
  input wire logic       o_square_wave_enable, o_frequency_test,
  input wire logic [4:0] o_watchdog_multiplier,
  input wire logic       o_halt_flag, o_osc_fail_flag, o_timer_enable,
  input wire logic [2:0] o_rate_select_upper,
  input wire logic       o_cal_source_select
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_srst);
  chk_first_group: assert property (
    i_power_up && !i_retained |=> o_output_level && o_square_wave_enable
    && !o_oscillator_stop && !o_frequency_test) else $error("group one");
  chk_ret_clear: assert property (
    i_power_up && i_retained |=> !o_frequency_test
    && o_watchdog_multiplier == 5'h00) else $error("retained clear");
  chk_ret_keep: assert property (
    i_power_up && i_retained |=> $stable(o_output_level)
    && $stable(o_square_wave_enable)) else $error("retained keep");
  chk_second_group: assert property (
    i_power_up && !i_retained |=> o_halt_flag && o_osc_fail_flag
    && !o_timer_enable && o_rate_select_upper == 3'h0
    && !o_cal_source_select) else $error("group two");
  chk_ret_halt: assert property (
    i_power_up && i_retained |=> o_halt_flag && !o_timer_enable
    && $stable(o_osc_fail_flag)) else $error("retained halt");
  chk_factory_trim: assert property (
    o_trim_valid && o_cal_source_select && !i_power_up
    |=> o_analog_trim == FACTORY_TRIM) else $error("factory trim");
  chk_select_take: assert property (
    i_otp_select_wr && !i_power_up
    |=> o_cal_source_select == $past(i_otp_select_val)) else $error("select");
  chk_trim_write: assert property (
    i_reg_wr && i_reg_addr == 8'h12 && !o_cal_source_select && !i_power_up
    && !i_otp_select_wr |=> ##1 o_analog_trim == $past(i_reg_wdata, 2))
    else $error("trim write");
endmodule // pwr_defaults_asserts
bind pwr_defaults pwr_defaults_asserts #(.FACTORY_TRIM(FACTORY_TRIM)) chk (
  .i_clock, .i_srst, .i_power_up, .i_retained, .i_reg_wr, .i_otp_select_wr,
  .i_otp_select_val, .i_reg_addr, .i_reg_wdata, .o_analog_trim,
  .o_trim_valid, .o_oscillator_stop, .o_output_level, .o_square_wave_enable,
  .o_frequency_test, .o_watchdog_multiplier, .o_halt_flag, .o_osc_fail_flag,
  .o_timer_enable, .o_rate_select_upper, .o_cal_source_select);

// ===== bench/testbench.sv
`timescale 1ns/1ns
module testbench;
  localparam [7:0] TRIM = 8'h5a; // arbitrary factory value
  logic       i_clock = 0, i_srst = 1, i_power_up = 0, i_retained = 0;
  logic       i_reg_wr, i_otp_select_wr, i_otp_select_val;
  logic [7:0] i_reg_addr, i_reg_wdata, d;
  wire  [7:0] o_analog_trim;
  wire        o_trim_valid;
  wire        o_output_level, o_halt_flag, o_timer_enable, o_cal_source_select;
  integer     err_count = 0, cmp_count = 0, seed = 17, i;
  host_model host (.i_clock, .o_wr(i_reg_wr), .o_sel_wr(i_otp_select_wr),
    .o_sel_val(i_otp_select_val), .o_addr(i_reg_addr), .o_data(i_reg_wdata));
  pwr_defaults #(.OTP_CYCLES(8), .FACTORY_TRIM(TRIM)) uut (.i_clock, .i_srst,
    .i_power_up, .i_retained, .i_reg_wr, .i_reg_addr, .i_reg_wdata,
    .i_otp_select_wr, .i_otp_select_val, .o_analog_trim, .o_trim_valid,
    .o_oscillator_stop(), .o_century_bit_hi(), .o_century_bit_lo(),
    .o_output_level, .o_frequency_test(), .o_digital_cal_sign(),
    .o_analog_cal_sign(), .o_digital_cal(), .o_osc_fail_irq_enable(),
    .o_watchdog_multiplier(), .o_watchdog_resolution_lo(),
    .o_watchdog_resolution_hi(), .o_alarm_one_irq_enable(),
    .o_square_wave_enable(), .o_alarm_in_backup_enable(),
    .o_alarm_one_repeat(), .o_halt_flag, .o_osc_fail_flag(), .o_timer_enable,
    .o_timer_irq_pulse_select(), .o_timer_irq_enable(), .o_timer_freq_hi(),
    .o_timer_freq_lo(), .o_rate_select_zero(), .o_rate_select_upper(),
    .o_cal_source_select, .o_alarm_two_repeat(), .o_alarm_two_enable());
  // trim expected after a host write
  function logic [7:0] exp_trim(input logic s, input logic [7:0] o, w);
    return s ? o : w;
  endfunction
  task chk(input string n, input logic [7:0] e, g);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("wrong value %s exp %h got %h", n, e, g);
    end
  endtask
  task pu(input logic r);
    @(posedge i_clock) #1;
    {i_power_up, i_retained} = {1'b1, r};
    @(posedge i_clock) #1;
    i_power_up = 0;
    @(posedge i_clock) #1;
  endtask
  task summarize;
    if (err_count == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial forever #50 i_clock = ~i_clock;
  initial begin
    #200000;
    err_count++;
    summarize;
  end
  // reset, plain writes, factory load, then both power-up kinds
  initial begin
    repeat (8) @(posedge i_clock);
    #1 i_srst = 0;
    chk("trim", 8'h00, o_analog_trim);
    chk("halt", 8'h01, {7'h0, o_halt_flag});
    for (i = 0; i < 6; i++) begin
      d = $random(seed);
      host.wr(8'h12, d);
      host.wr(8'h13, ~d);
      repeat (2) @(posedge i_clock) #1;
      chk("trim", exp_trim(0, 8'h00, d), o_analog_trim);
    end
    host.sel(1);
    chk("trim", TRIM, o_analog_trim);
    chk("valid", 8'h01, {7'h0, o_trim_valid});
    host.wr(8'h12, ~TRIM);
    repeat (2) @(posedge i_clock) #1;
    chk("trim", exp_trim(1, TRIM, ~TRIM), o_analog_trim);
    pu(1);
    chk("halt", 8'h01, {7'h0, o_halt_flag});
    chk("timer", 8'h00, {7'h0, o_timer_enable});
    chk("select", 8'h01, {7'h0, o_cal_source_select});
    chk("trim", TRIM, o_analog_trim);
    pu(0);
    chk("select", 8'h00, {7'h0, o_cal_source_select});
    chk("level", 8'h01, {7'h0, o_output_level});
    chk("trim", 8'h00, o_analog_trim);
    chk("valid", 8'h00, {7'h0, o_trim_valid});
    summarize;
  end
endmodule // testbench

// ===== rtl/pwr_defaults.v
`timescale 1ns/1ns
`include "pwr_defaults_regs.vh"
// power-on defaults and factory trim load for the clock control bits
module pwr_defaults #(
  parameter OTP_CYCLES = `OTP_READ_CYCLES,
  parameter [7:0] FACTORY_TRIM = 8'h00   // arbitrary neutral default
) (
  input  wire       i_clock,
  input  wire       i_srst,
  input  wire       i_power_up,       // one-cycle power-up event
  input  wire       i_retained,       // backup supply kept contents
  input  wire       i_reg_wr,
  input  wire [7:0] i_reg_addr,
  input  wire [7:0] i_reg_wdata,
  input  wire       i_otp_select_wr,  // host write of select bit
  input  wire       i_otp_select_val,
  output reg  [7:0] o_analog_trim,
  output reg        o_trim_valid,
  output reg        o_oscillator_stop,
  output reg        o_century_bit_hi,
  output reg        o_century_bit_lo,
  output reg        o_output_level,
  output reg        o_frequency_test,
  output reg        o_digital_cal_sign,
  output reg        o_analog_cal_sign,
  output reg  [4:0] o_digital_cal,
  output reg        o_osc_fail_irq_enable,
  output reg  [4:0] o_watchdog_multiplier,
  output reg        o_watchdog_resolution_lo,
  output reg        o_watchdog_resolution_hi,
  output reg        o_alarm_one_irq_enable,
  output reg        o_square_wave_enable,
  output reg        o_alarm_in_backup_enable,
  output reg  [4:0] o_alarm_one_repeat,
  output reg        o_halt_flag,
  output reg        o_osc_fail_flag,
  output reg        o_timer_enable,
  output reg        o_timer_irq_pulse_select,
  output reg        o_timer_irq_enable,
  output reg        o_timer_freq_hi,
  output reg        o_timer_freq_lo,
  output reg        o_rate_select_zero,
  output reg  [2:0] o_rate_select_upper,
  output reg        o_cal_source_select,
  output reg  [4:0] o_alarm_two_repeat,
  output reg        o_alarm_two_enable
);
  localparam ST_IDLE = 1'b0;
  localparam ST_LOAD = 1'b1;

  reg        state_q;
  reg [23:0] wait_q;
  reg [7:0]  trim_wdata;
  reg        trim_wr;
  wire [7:0] trim_rdata;
  wire       init_up   = i_power_up & ~i_retained;
  wire       retain_up = i_power_up & i_retained;
  wire       host_trim = i_reg_wr & (i_reg_addr == `ANALOG_TRIM_OFFSET);

  // trim storage write source: power-up reset value, factory load or host write
  always @* begin
    trim_wr    = 1'b0;
    trim_wdata = i_reg_wdata;
    if (init_up) begin
      trim_wr    = 1'b1;
      trim_wdata = `ANALOG_TRIM_RESET;
    end else if (state_q == ST_LOAD && wait_q == 24'h000000) begin
      trim_wr    = 1'b1;
      trim_wdata = FACTORY_TRIM;
    end else if (host_trim && !o_cal_source_select) begin
      trim_wr = 1'b1;
    end
  end

  trim_store #(.WIDTH(8)) u_trim (
    .i_clock (i_clock),
    .i_srst  (i_srst),
    .i_wr    (trim_wr),
    .i_wdata (trim_wdata),
    .o_rdata (trim_rdata)
  );

  // trim output follows store; no reset of its own, store holds it
  // bits outside the named default sets keep no promised start value
  always @(posedge i_clock) begin
    o_analog_trim <= trim_rdata;
  end

  // factory trim read sequencer, busy for the otp read time
  always @(posedge i_clock) begin
    if (i_srst || init_up) begin
      state_q      <= ST_IDLE;
      wait_q       <= 24'h000000;
      o_trim_valid <= 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (i_otp_select_wr && i_otp_select_val) begin
            state_q      <= ST_LOAD;
            wait_q       <= OTP_CYCLES[23:0] - 24'h000001;
            o_trim_valid <= 1'b0;
          end else if (i_otp_select_wr) begin
            o_trim_valid <= 1'b0;
          end
        end
        ST_LOAD: begin
          if (wait_q == 24'h000000) begin
            state_q      <= ST_IDLE;
            o_trim_valid <= 1'b1;
          end else begin
            wait_q <= wait_q - 24'h000001;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // first control group: initial defaults, retained clears
  always @(posedge i_clock) begin
    if (i_srst || init_up) begin
      o_oscillator_stop        <= 1'b0;
      o_century_bit_hi         <= 1'b0;
      o_century_bit_lo         <= 1'b0;
      o_output_level           <= 1'b1;
      o_frequency_test         <= 1'b0;
      o_digital_cal_sign       <= 1'b0;
      o_analog_cal_sign        <= 1'b0;
      o_digital_cal            <= 5'h00;
      o_osc_fail_irq_enable    <= 1'b0;
      o_watchdog_multiplier    <= 5'h00;
      o_watchdog_resolution_lo <= 1'b0;
      o_watchdog_resolution_hi <= 1'b0;
      o_alarm_one_irq_enable   <= 1'b0;
      o_square_wave_enable     <= 1'b1;
      o_alarm_in_backup_enable <= 1'b0;
    end else if (retain_up) begin
      // only these bits move; the rest of the group holds
      o_frequency_test         <= 1'b0;
      o_watchdog_multiplier    <= 5'h00;
      o_watchdog_resolution_lo <= 1'b0;
      o_watchdog_resolution_hi <= 1'b0;
    end
  end

  // second control group: initial defaults, retained halt
  always @(posedge i_clock) begin
    if (i_srst || init_up) begin
      o_alarm_one_repeat       <= 5'h00;
      o_halt_flag              <= 1'b1;
      o_osc_fail_flag          <= 1'b1;
      o_timer_enable           <= 1'b0;
      o_timer_irq_pulse_select <= 1'b0;
      o_timer_irq_enable       <= 1'b0;
      o_timer_freq_hi          <= 1'b1;
      o_timer_freq_lo          <= 1'b1;
      o_rate_select_zero       <= 1'b1;
      o_rate_select_upper      <= 3'h0;
      o_cal_source_select      <= 1'b0;
      o_alarm_two_repeat       <= 5'h00;
      o_alarm_two_enable       <= 1'b0;
    end else if (retain_up) begin
      // power-up wins over a same-cycle select write for the select bit; the trim sequencer still takes it
      o_halt_flag              <= 1'b1;
      o_timer_enable           <= 1'b0;
    end else if (i_otp_select_wr) begin
      o_cal_source_select <= i_otp_select_val;
    end
  end
endmodule // pwr_defaults

// ===== rtl/pwr_defaults_regs.vh
// What this block does
// - initial power-up forces first-group control defaults
// - retained power-up clears frequency test, watchdog bits
// - initial power-up forces second-group control defaults
// - retained power-up sets halt, clears timer enable
// - unnamed control bits have no guaranteed start value
// - select high loads factory trim, register read-only
// - select low makes trim register plain read/write
`ifndef PWR_DEFAULTS_REGS_VH
`define PWR_DEFAULTS_REGS_VH
`define ANALOG_TRIM_OFFSET  8'h12
`define ANALOG_TRIM_RESET   8'h00
`define OTP_READ_TIME_MS    8
`define CLOCK_HZ            10000000
`define OTP_READ_CYCLES     (`OTP_READ_TIME_MS * (`CLOCK_HZ / 1000))
`define WDOG_MULT_WIDTH     5
`define ALARM_RPT_WIDTH     5
`define RATE_UPPER_WIDTH    3
`endif

// ===== rtl/trim_store.v
`timescale 1ns/1ns
// holds the analog trim byte; read data comes out of a register
module trim_store #(
  parameter WIDTH = 8
) (
  input  wire             i_clock,
  input  wire             i_srst,
  input  wire             i_wr,
  input  wire [WIDTH-1:0] i_wdata,
  output reg  [WIDTH-1:0] o_rdata
);
  // one storage word, cleared by reset
  always @(posedge i_clock) begin
    if (i_srst) begin
      o_rdata <= {WIDTH{1'b0}};
    end else if (i_wr) begin
      o_rdata <= i_wdata;
    end
  end
endmodule // trim_store
